//--- design/iofc_regs.sv
//----------------------------------------------------------------------
// Purpose: Configuration bank for serial B routing, clock and keyboard
// Assumes: Avalon-MM slave, one wait cycle, byte lane 0 carries data
// Notes: All outputs registered; clkEn low freezes every flop
//----------------------------------------------------------------------
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
module iofc_regs (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rtcIrqRaw,
   output logic [15:0] serBIrqSel,
   output logic rtcEnable,
   output logic rtcPowerDown,
   output logic rtcIrq8Oe,
   output logic rtcIrq8ActiveHigh,
   output logic rtcIrq8Out,
   output logic kbdUnitEnable,
   output logic kbdUnitPowerDown,
   output logic kbdUnitPinIsolate,
   output logic kbdUnitClk12MHz,
   output logic kbdIrq1Oe,
   output logic kbdIrq12Oe,
   output logic kbdFastLatchEn
);

   //-------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------
   iofc_pkg::iofc_state_t q;
   iofc_pkg::iofc_state_t next_q;
   logic [5:0] regIdx;
   logic [7:0] wrByte;
   logic [15:0] decSel;
   logic wrCommit;
   logic [3:0] nextCode;

   localparam iofc_pkg::iofc_state_t IOFC_Q_RST = '{
      st: iofc_pkg::IOFC_IDLE,
      waitReq: 1'b1,
      rdData: 32'h0000_0000,
      serbReg: iofc_pkg::IOFC_SERB_RST,
      rtcReg: iofc_pkg::IOFC_RTC_RST,
      kbdReg: iofc_pkg::IOFC_KBD_RST,
      irqSel: 16'h0000,
      rtcEn: 1'b0,
      rtcPd: 1'b1,
      irq8Oe: 1'b0,
      irq8Pol: 1'b0,
      irq8Out: 1'b1,
      kbdEn: 1'b0,
      kbdPd: 1'b1,
      kbdIso: 1'b0,
      kbdClk12: 1'b0,
      irq1Oe: 1'b1,
      irq12Oe: 1'b1,
      fastLatch: 1'b0
   };

   assign regIdx = avs_address[iofc_pkg::IOFC_ADDR_W-1:iofc_pkg::IOFC_IDX_LSB];
   assign wrByte = avs_writedata[7:0];
   assign wrCommit = (q.st == iofc_pkg::IOFC_ACK) && avs_write && avs_byteenable[0];
   // Routing code after this edge, kept apart from the state copy
   assign nextCode = (wrCommit && regIdx == iofc_pkg::IOFC_IDX_SERB) ? wrByte[3:0]
                     : q.serbReg[3:0];

   //-------------------------------------------------------------------
   // Routing decode
   //-------------------------------------------------------------------
   iofc_irq_decode u_decode (
      .code(nextCode),
      .lineSel(decSel)
   );

   //-------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------
   always_comb begin
      next_q = q;
      case (q.st)
         iofc_pkg::IOFC_IDLE: begin
            if (avs_read || avs_write) begin
               next_q.st = iofc_pkg::IOFC_ACK;
               next_q.waitReq = 1'b0;
               next_q.rdData = 32'h0000_0000;
               if (avs_read) begin
                  case (regIdx)
                     iofc_pkg::IOFC_IDX_SERB: next_q.rdData[7:0] = q.serbReg;
                     iofc_pkg::IOFC_IDX_RTC: next_q.rdData[7:0] = q.rtcReg;
                     iofc_pkg::IOFC_IDX_KBD: next_q.rdData[7:0] = q.kbdReg;
                     default: next_q.rdData = 32'h0000_0000;
                  endcase
               end
            end
         end
         iofc_pkg::IOFC_ACK: begin
            next_q.st = iofc_pkg::IOFC_IDLE;
            next_q.waitReq = 1'b1;
            if (wrCommit) begin
               case (regIdx)
                  iofc_pkg::IOFC_IDX_SERB:
                     next_q.serbReg = wrByte | iofc_pkg::IOFC_SERB_RSVD;
                  iofc_pkg::IOFC_IDX_RTC:
                     next_q.rtcReg = wrByte | iofc_pkg::IOFC_RTC_RSVD;
                  iofc_pkg::IOFC_IDX_KBD:
                     next_q.kbdReg = wrByte | iofc_pkg::IOFC_KBD_RSVD;
                  default: next_q.serbReg = q.serbReg;
               endcase
            end
         end
         default: begin
            next_q.st = iofc_pkg::IOFC_IDLE;
            next_q.waitReq = 1'b1;
         end
      endcase

      next_q.irqSel = decSel;
      next_q.rtcEn = next_q.rtcReg[iofc_pkg::IOFC_RTC_EN_BIT];
      next_q.rtcPd = !next_q.rtcReg[iofc_pkg::IOFC_RTC_EN_BIT];
      next_q.irq8Oe = next_q.rtcReg[iofc_pkg::IOFC_RTC_EN_BIT];
      next_q.irq8Pol = next_q.rtcReg[iofc_pkg::IOFC_RTC_POL_BIT];
      next_q.irq8Out = rtcIrqRaw ~^ q.rtcReg[iofc_pkg::IOFC_RTC_POL_BIT];
      next_q.kbdEn = next_q.kbdReg[iofc_pkg::IOFC_KBD_EN_BIT];
      next_q.kbdPd = !next_q.kbdReg[iofc_pkg::IOFC_KBD_EN_BIT];
      next_q.kbdIso = next_q.kbdReg[iofc_pkg::IOFC_KBD_LEAK_BIT]
                      && !next_q.kbdReg[iofc_pkg::IOFC_KBD_EN_BIT];
      next_q.kbdClk12 = next_q.kbdReg[iofc_pkg::IOFC_KBD_CLK_BIT];
      next_q.irq1Oe = !next_q.kbdReg[iofc_pkg::IOFC_KBD_IRQ1Z_BIT];
      next_q.irq12Oe = !next_q.kbdReg[iofc_pkg::IOFC_KBD_IRQ12Z_BIT];
      next_q.fastLatch = next_q.kbdReg[iofc_pkg::IOFC_KBD_FAST_BIT];
   end

   //-------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         q <= IOFC_Q_RST;
      end else if (clkEn) begin
         q <= next_q;
      end
   end

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------
   assign avs_readdata = q.rdData;
   assign avs_waitrequest = q.waitReq;
   assign serBIrqSel = q.irqSel;
   assign rtcEnable = q.rtcEn;
   assign rtcPowerDown = q.rtcPd;
   assign rtcIrq8Oe = q.irq8Oe;
   assign rtcIrq8ActiveHigh = q.irq8Pol;
   assign rtcIrq8Out = q.irq8Out;
   assign kbdUnitEnable = q.kbdEn;
   assign kbdUnitPowerDown = q.kbdPd;
   assign kbdUnitPinIsolate = q.kbdIso;
   assign kbdUnitClk12MHz = q.kbdClk12;
   assign kbdIrq1Oe = q.irq1Oe;
   assign kbdIrq12Oe = q.irq12Oe;
   assign kbdFastLatchEn = q.fastLatch;

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   logic rdAck;
   assign rdAck = (q.st == iofc_pkg::IOFC_ACK) && avs_read;

   a_route_onehot: assert property (
      $onehot0(serBIrqSel) && ((serBIrqSel & ~iofc_pkg::IOFC_IRQ_VALID) == 16'h0000))
      else $error("routing select not one-hot or reserved line");

   a_route_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_SERB && wrByte[3:0] == 4'h3)
      |=> (serBIrqSel == 16'h0008))
      else $error("code three did not select line 3");

   a_rsvd_read: assert property (
      rdAck && !avs_waitrequest |->
      ((regIdx == iofc_pkg::IOFC_IDX_SERB) -> (avs_readdata[7:4] == 4'hF)) &&
      ((regIdx == iofc_pkg::IOFC_IDX_RTC) -> (avs_readdata[7:2] == 6'h3F)) &&
      ((regIdx == iofc_pkg::IOFC_IDX_KBD) -> (avs_readdata[7:6] == 2'h3)))
      else $error("reserved bits did not read as one");

   a_rtc_enable: assert property (
      (rtcIrq8Oe == rtcEnable) && (rtcPowerDown == !rtcEnable))
      else $error("clock enable, power down and line 8 drive disagree");

   a_irq8_polarity: assert property (
      clkEn |=> (rtcIrq8Out == ($past(rtcIrqRaw) ~^ $past(rtcIrq8ActiveHigh))))
      else $error("line 8 level does not follow polarity");

   a_kbd_enable: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdUnitEnable == $past(wrByte[0])) && (kbdUnitPowerDown == !$past(wrByte[0])))
      else $error("controller enable not taken from write");

   a_kbd_isolate: assert property (
      kbdUnitPinIsolate == (kbdUnitPowerDown && q.kbdReg[iofc_pkg::IOFC_KBD_LEAK_BIT]))
      else $error("pin isolation outside power down");

   a_kbd_clock: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdUnitClk12MHz == $past(wrByte[2])))
      else $error("controller clock select wrong");

   a_irq1_hiz: assert property (
      kbdIrq1Oe == !q.kbdReg[iofc_pkg::IOFC_KBD_IRQ1Z_BIT])
      else $error("line 1 drive does not match control");

   a_irq12_hiz: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdIrq12Oe == !$past(wrByte[4])))
      else $error("line 12 drive not taken from write");

   a_fast_latch: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdFastLatchEn == $past(wrByte[5])))
      else $error("fast latch enable not taken from write");

   a_rsvd_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_RTC && wrByte == 8'h00)
      |=> (q.rtcReg == 8'hFC) && !rtcEnable)
      else $error("reserved clock bits changed by write");

   // Bus answer one wait cycle
   a_bus_answer: assert property (
      (avs_waitrequest && (avs_read || avs_write) && clkEn)
      |=> !avs_waitrequest ##1 (avs_waitrequest || !$past(clkEn)))
      else $error("bus answer not one wait cycle");

   a_rtc_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_RTC)
      |=> (rtcEnable == $past(wrByte[0])) && (rtcIrq8Oe == $past(wrByte[0]))
          && (rtcPowerDown == !$past(wrByte[0])))
      else $error("clock enable group not taken from write");

   a_pol_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_RTC)
      |=> (rtcIrq8ActiveHigh == $past(wrByte[1])))
      else $error("line 8 polarity not taken from write");

   a_iso_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdUnitPinIsolate == ($past(wrByte[1]) && !$past(wrByte[0]))))
      else $error("pin isolation not taken from write");

   a_irq1_write: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (kbdIrq1Oe == !$past(wrByte[3])))
      else $error("line 1 drive not taken from write");

   a_kbd_rsvd: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD)
      |=> (q.kbdReg[7:6] == 2'h3))
      else $error("reserved keyboard bits changed by write");

   a_serb_rsvd: assert property (
      (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_SERB)
      |=> (q.serbReg[7:4] == 4'hF))
      else $error("reserved routing bits changed by write");

   a_route_hold: assert property (
      !(wrCommit && regIdx == iofc_pkg::IOFC_IDX_SERB) |=> $stable(serBIrqSel))
      else $error("routing select changed without a write");

   a_rdata_upper: assert property (
      !avs_waitrequest |-> (avs_readdata[31:8] == 24'h000000))
      else $error("upper read data lanes not zero");

   c_read_ack: cover property (rdAck && regIdx == iofc_pkg::IOFC_IDX_KBD);
   c_stretch: cover property (!avs_waitrequest && !clkEn);
   c_write_kbd: cover property (wrCommit && clkEn && regIdx == iofc_pkg::IOFC_IDX_KBD);
   c_route_15: cover property (serBIrqSel == 16'h8000);
   c_rtc_on: cover property (rtcEnable && rtcIrq8ActiveHigh);

endmodule : iofc_regs

//--- design/iofc_pkg.sv
//----------------------------------------------------------------------
// Purpose: Constants and types of the I/O function configuration bank
// Assumes: Avalon-MM byte addresses, register index times four
// Notes: Operation
//----------------------------------------------------------------------
// Operation
// - Serial B routing low nibble picks interrupt line; zero none; others reserved
// - Reserved bits of all three registers read back as ones
// - Clock bit 0 low: clock unmapped, powered down, line 8 tristated
// - Clock bit 1 sets line 8 polarity: zero low, one high
// - Keyboard bit 0 low: controller unmapped and held in power down
// - Keyboard bit 1 one: outputs tristated, inputs blocked during power down
// - Keyboard bit 2 selects controller clock: zero 8 MHz, one 12 MHz
// - Keyboard bit 3 one puts interrupt line 1 in high impedance
// - Keyboard bit 4 one puts interrupt line 12 in high impedance
// - Keyboard bit 5 one enables fast latching of lines 1 and 12
package iofc_pkg;

   //-------------------------------------------------------------------
   // Register indices and bus widths
   //-------------------------------------------------------------------
   localparam int IOFC_ADDR_W = 8;
   localparam int IOFC_DATA_W = 32;
   localparam int IOFC_IDX_LSB = 2;
   localparam logic [5:0] IOFC_IDX_SERB = 6'h15;
   localparam logic [5:0] IOFC_IDX_RTC = 6'h16;
   localparam logic [5:0] IOFC_IDX_KBD = 6'h18;

   //-------------------------------------------------------------------
   // Reset values and reserved masks
   //-------------------------------------------------------------------
   localparam logic [7:0] IOFC_SERB_RST = 8'hF0;
   localparam logic [7:0] IOFC_RTC_RST = 8'hFC;
   localparam logic [7:0] IOFC_KBD_RST = 8'hC0;
   localparam logic [7:0] IOFC_SERB_RSVD = 8'hF0;
   localparam logic [7:0] IOFC_RTC_RSVD = 8'hFC;
   localparam logic [7:0] IOFC_KBD_RSVD = 8'hC0;

   //-------------------------------------------------------------------
   // Field positions
   //-------------------------------------------------------------------
   localparam int IOFC_RTC_EN_BIT = 0;
   localparam int IOFC_RTC_POL_BIT = 1;
   localparam int IOFC_KBD_EN_BIT = 0;
   localparam int IOFC_KBD_LEAK_BIT = 1;
   localparam int IOFC_KBD_CLK_BIT = 2;
   localparam int IOFC_KBD_IRQ1Z_BIT = 3;
   localparam int IOFC_KBD_IRQ12Z_BIT = 4;
   localparam int IOFC_KBD_FAST_BIT = 5;

   //-------------------------------------------------------------------
   // Interrupt routing
   //-------------------------------------------------------------------
   localparam int IOFC_IRQ_LINES = 16;
   localparam logic [15:0] IOFC_IRQ_VALID = 16'hCEF8;

   //-------------------------------------------------------------------
   // Bus states and module state
   //-------------------------------------------------------------------
   typedef enum logic [0:0] {
      IOFC_IDLE = 1'b0,
      IOFC_ACK = 1'b1
   } iofc_bus_t;

   typedef struct packed {
      iofc_bus_t st;
      logic waitReq;
      logic [31:0] rdData;
      logic [7:0] serbReg;
      logic [7:0] rtcReg;
      logic [7:0] kbdReg;
      logic [15:0] irqSel;
      logic rtcEn;
      logic rtcPd;
      logic irq8Oe;
      logic irq8Pol;
      logic irq8Out;
      logic kbdEn;
      logic kbdPd;
      logic kbdIso;
      logic kbdClk12;
      logic irq1Oe;
      logic irq12Oe;
      logic fastLatch;
   } iofc_state_t;

endpackage : iofc_pkg

//--- design/iofc_irq_decode.sv
//----------------------------------------------------------------------
// Purpose: Decodes the serial B routing code into one-hot line selects
// Assumes: Pure combinational, used inside the register bank
// Notes: Reserved codes and code zero select no line
//----------------------------------------------------------------------
`timescale 1ns/100ps
module iofc_irq_decode (
   input wire logic [3:0] code,
   output logic [15:0] lineSel
);

   //-------------------------------------------------------------------
   // Per line decode
   //-------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < iofc_pkg::IOFC_IRQ_LINES; gi++) begin : g_line
         assign lineSel[gi] = (code == 4'(gi)) && iofc_pkg::IOFC_IRQ_VALID[gi];
      end
   endgenerate

endmodule : iofc_irq_decode

//--- dv/iofc_regs_tb_top.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the I/O function configuration bank
// Assumes: Avalon-MM master tasks, fixed seed, one clock domain
// Notes: Model keeps expected register bytes; outputs derived from them
//----------------------------------------------------------------------
`timescale 1ns/100ps
module iofc_regs_tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic clkEn = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic rtcIrqRaw = 1'b0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] serBIrqSel;
   logic rtcEnable, rtcPowerDown, rtcIrq8Oe, rtcIrq8ActiveHigh, rtcIrq8Out;
   logic kbdUnitEnable, kbdUnitPowerDown, kbdUnitPinIsolate, kbdUnitClk12MHz;
   logic kbdIrq1Oe, kbdIrq12Oe, kbdFastLatchEn;
   logic [7:0] expReg [3];
   logic randEn = 1'b0;
   int fail_count = 0;
   int total_checks = 0;

   always #5 ref_clk = ~ref_clk;

   iofc_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rtcIrqRaw(rtcIrqRaw), .serBIrqSel(serBIrqSel), .rtcEnable(rtcEnable),
      .rtcPowerDown(rtcPowerDown), .rtcIrq8Oe(rtcIrq8Oe),
      .rtcIrq8ActiveHigh(rtcIrq8ActiveHigh), .rtcIrq8Out(rtcIrq8Out),
      .kbdUnitEnable(kbdUnitEnable), .kbdUnitPowerDown(kbdUnitPowerDown),
      .kbdUnitPinIsolate(kbdUnitPinIsolate), .kbdUnitClk12MHz(kbdUnitClk12MHz),
      .kbdIrq1Oe(kbdIrq1Oe), .kbdIrq12Oe(kbdIrq12Oe), .kbdFastLatchEn(kbdFastLatchEn));

   // Clock enable, random only in the stretch phase
   always @(posedge ref_clk) begin
      clkEn <= randEn ? (($urandom() % 3) != 0) : 1'b1;
   end

   //-------------------------------------------------------------------
   // Expectation functions and compare tasks
   //-------------------------------------------------------------------
   function automatic logic [15:0] exp_sel(input logic [3:0] code);
      logic [15:0] r;
      r = 16'h0000;
      if ((code >= 4'h3 && code <= 4'h7) || (code >= 4'h9 && code <= 4'hB) || code >= 4'hE) begin
         r[code] = 1'b1;
      end
      return r;
   endfunction : exp_sel

   function automatic int reg_slot(input logic [7:0] addr);
      case (addr[7:2])
         6'h15: return 0;
         6'h16: return 1;
         6'h18: return 2;
         default: return -1;
      endcase
   endfunction : reg_slot

   function automatic logic [7:0] rsvd(input int s);
      return (s == 0) ? 8'hF0 : ((s == 1) ? 8'hFC : 8'hC0);
   endfunction : rsvd

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: read data %h, expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
      end
   endtask : chk_pin

   //-------------------------------------------------------------------
   // Bus master tasks
   //-------------------------------------------------------------------
   task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
         input logic [3:0] be, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= addr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((avs_waitrequest !== 1'b0 || clkEn !== 1'b1) && n < 200);
      rd = avs_readdata;
      if (n >= 200) begin
         fail_count++;
         $display("Error at %0t: no answer on the bus", $time);
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus_xfer

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] d, input logic [3:0] be);
      logic [31:0] rd;
      int s;
      s = reg_slot(addr);
      bus_xfer(1'b1, addr, {24'($urandom()), d}, be, rd);
      if (s >= 0 && be[0]) begin
         expReg[s] = d | rsvd(s);
      end
   endtask : reg_write

   task automatic reg_read(input logic [7:0] addr);
      logic [31:0] rd;
      int s;
      s = reg_slot(addr);
      bus_xfer(1'b0, addr, 32'($urandom()), 4'($urandom()), rd);
      chk_data(rd, (s >= 0) ? {24'h000000, expReg[s]} : 32'h00000000);
   endtask : reg_read

   task automatic check_outs();
      logic [7:0] c;
      logic [7:0] k;
      logic raw;
      c = expReg[1];
      k = expReg[2];
      raw = 1'($urandom());
      @(posedge ref_clk);
      rtcIrqRaw <= raw;
      @(posedge ref_clk);
      #1;
      chk_pin(serBIrqSel, exp_sel(expReg[0][3:0]), "line select");
      chk_pin({rtcEnable, rtcPowerDown, rtcIrq8Oe}, {c[0], !c[0], c[0]}, "clock en");
      chk_pin({rtcIrq8ActiveHigh, rtcIrq8Out}, {c[1], !(raw ^ c[1])}, "line 8");
      chk_pin({kbdUnitEnable, kbdUnitPowerDown}, {k[0], !k[0]}, "kbd en");
      chk_pin(kbdUnitPinIsolate, k[1] & !k[0], "kbd isolate");
      chk_pin(kbdUnitClk12MHz, k[2], "kbd clock");
      chk_pin(kbdIrq1Oe, !k[3], "line 1 oe");
      chk_pin(kbdIrq12Oe, !k[4], "line 12 oe");
      chk_pin(kbdFastLatchEn, k[5], "fast latch");
   endtask : check_outs

   function automatic logic [7:0] rand_addr();
      case ($urandom() % 4)
         0: return 8'h54 | 8'($urandom() % 4);
         1: return 8'h58 | 8'($urandom() % 4);
         2: return 8'h60 | 8'($urandom() % 4);
         default: return 8'($urandom());
      endcase
   endfunction : rand_addr

   task automatic reset_and_read();
      expReg = '{8'hF0, 8'hFC, 8'hC0};
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      nrst <= 1'b1;
      reg_read(8'h54);
      reg_read(8'h58);
      reg_read(8'h60);
      check_outs();
   endtask : reset_and_read

   task automatic report_and_stop();
      $display("Checks made %0d, errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial begin
      logic [7:0] a;
      logic [15:0] corner [8];
      void'($urandom(32'h9C25));
      corner = '{16'h5800, 16'h5803, 16'h5801, 16'h603F, 16'h6002, 16'h6003, 16'h6018, 16'h60FF};
      reset_and_read();
      for (int i = 0; i < 16; i++) begin
         reg_write(8'h54, {4'($urandom()), 4'(i)}, 4'h1);
         reg_read(8'h54);
         check_outs();
      end
      foreach (corner[i]) begin
         reg_write(corner[i][15:8], corner[i][7:0], 4'hF);
         reg_read(corner[i][15:8]);
         check_outs();
      end
      // random traffic, unmapped and disabled lanes
      for (int i = 0; i < 80; i++) begin
         a = rand_addr();
         reg_write(a, 8'($urandom()), 4'($urandom()));
         reg_read(rand_addr());
         reg_read(a);
         check_outs();
      end
      randEn <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         a = rand_addr();
         reg_write(a, 8'($urandom()), 4'h1);
         reg_read(a);
      end
      randEn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check_outs();
      reset_and_read();
      report_and_stop();
   end

   // Watchdog
   initial begin
      #(20000 * 10);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule : iofc_regs_tb_top
